// ---- rtl/fepc_core_ctl.sv ----
// core-side controller: APB registers turned into register and move sequences
`timescale 1ns/1ps
module fepc_core_ctl
	import fepc_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	fepc_if.core             BUS,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR
);
	import fepc_pkg::*;

	typedef enum logic [1:0] {
		FEPC_H_IDLE,
		FEPC_H_ISSUE,
		FEPC_H_WAITR
	} fepc_hst_e;

	fepc_hst_e   st_q;
	fepc_kind_e  kind_q [2];
	logic [15:0] addr_q [2];
	logic [7:0]  data_q [2];
	logic        idx_q;
	logic [23:0] arg_q;
	logic        inten_q;
	logic [7:0]  rd_q;
	logic        stb_q;
	logic        setup;
	logic        wr_cmd;
	logic        taken;
	logic        mapped;
	fepc_op_e    op;
	logic [15:0] a_addr;
	logic [7:0]  a_data;

	assign setup  = PSEL & ~PENABLE;
	assign wr_cmd = setup & PWRITE & (PADDR == APB_CMD) & (st_q == FEPC_H_IDLE);
	assign taken  = stb_q & BUS.ready;
	assign mapped = (PADDR == APB_CMD) | (PADDR == APB_ARG) | (PADDR == APB_CFG) | (PADDR == APB_STATUS);
	assign op     = fepc_op_e'(PWDATA[2:0]);
	assign a_addr = arg_q[ARG_ADDR_MSB:ARG_ADDR_LSB];
	assign a_data = arg_q[ARG_DATA_MSB:ARG_DATA_LSB];

	// APB slave: every transfer answers in its first access cycle
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= WORD_ZERO;
			arg_q   <= '0;
			inten_q <= 1'b0;
		end
		else
		begin
			PREADY <= 1'b1;
			if (setup)
			begin
				PSLVERR <= ~mapped;
				PRDATA  <= WORD_ZERO;
				if (PWRITE && PADDR == APB_ARG)
				begin
					arg_q <= PWDATA[ARG_DATA_MSB:0];
				end
				if (PWRITE && PADDR == APB_CFG)
				begin
					inten_q <= PWDATA[CFG_INTEN_BIT];
				end
				if (!PWRITE)
				begin
					case (PADDR)
						APB_ARG:    PRDATA[ARG_DATA_MSB:0] <= arg_q;
						APB_CFG:    PRDATA[CFG_INTEN_BIT] <= inten_q;
						APB_STATUS:
						begin
							PRDATA[ST_BUSY_BIT]          <= (st_q != FEPC_H_IDLE);
							PRDATA[ST_READY_BIT]         <= BUS.ready;
							PRDATA[ST_RD_MSB:ST_RD_LSB]  <= rd_q;
						end
						default:    PRDATA <= WORD_ZERO;
					endcase
				end
			end
		end
	end

	// a command expands into at most two core accesses; pattern always after its setup
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			kind_q <= '{FEPC_K_NONE, FEPC_K_NONE};
			addr_q <= '{16'h0000, 16'h0000};
			data_q <= '{BYTE_ZERO, BYTE_ZERO};
		end
		else if (wr_cmd)
		begin
			kind_q <= '{FEPC_K_NONE, FEPC_K_NONE};
			case (op)
				FEPC_OP_PAGE:
				begin
					kind_q <= '{FEPC_K_SFRW, FEPC_K_SFRW};
					addr_q <= '{{8'h00, SFR_PAGE_ADDR}, {8'h00, SFR_ERASE_TRIG}};
					data_q <= '{{a_addr[PAGE_W-1:0], 1'b0}, PAT_PAGE_ERASE};
				end
				FEPC_OP_MASS:
				begin
					kind_q <= '{FEPC_K_SFRW, FEPC_K_SFRW};
					addr_q <= '{{8'h00, SFR_FLASH_CTL}, {8'h00, SFR_ERASE_TRIG}};
					data_q <= '{8'(1 << MEEN_BIT), PAT_MASS_ERASE};
				end
				FEPC_OP_PROG:
				begin
					kind_q <= '{FEPC_K_SFRW, FEPC_K_XMOV};
					addr_q <= '{{8'h00, SFR_FLASH_CTL}, a_addr};
					data_q <= '{8'(1 << PWE_BIT), a_data};
				end
				FEPC_OP_SFRW:
				begin
					kind_q <= '{FEPC_K_SFRW, FEPC_K_NONE};
					addr_q <= '{a_addr, 16'h0000};
					data_q <= '{a_data, BYTE_ZERO};
				end
				FEPC_OP_XWR:
				begin
					kind_q <= '{FEPC_K_XMOV, FEPC_K_NONE};
					addr_q <= '{a_addr, 16'h0000};
					data_q <= '{a_data, BYTE_ZERO};
				end
				FEPC_OP_SFRR:
				begin
					kind_q <= '{FEPC_K_SFRR, FEPC_K_NONE};
					addr_q <= '{a_addr, 16'h0000};
					data_q <= '{BYTE_ZERO, BYTE_ZERO};
				end
				default:
				begin
					kind_q <= '{FEPC_K_NONE, FEPC_K_NONE};
				end
			endcase
		end
	end

	// access sequencer; a strobe stands until the device is ready to take it
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			st_q  <= FEPC_H_IDLE;
			idx_q <= 1'b0;
			stb_q <= 1'b0;
			rd_q  <= BYTE_ZERO;
		end
		else
		begin
			case (st_q)
				FEPC_H_IDLE:
				begin
					idx_q <= 1'b0;
					if (wr_cmd && op != FEPC_OP_NONE && op <= FEPC_OP_SFRR)
					begin
						st_q  <= FEPC_H_ISSUE;
						stb_q <= 1'b1;
					end
				end
				FEPC_H_ISSUE:
				begin
					if (taken)
					begin
						stb_q <= 1'b0;
						if (kind_q[idx_q] == FEPC_K_SFRR)
						begin
							st_q <= FEPC_H_WAITR;
						end
						else if (!idx_q && kind_q[1] != FEPC_K_NONE)
						begin
							idx_q <= 1'b1;
						end
						else
						begin
							st_q <= FEPC_H_IDLE;
						end
					end
					else
					begin
						stb_q <= 1'b1;
					end
				end
				FEPC_H_WAITR:
				begin
					if (BUS.sfr_rvalid)
					begin
						rd_q <= BUS.sfr_rdata;
						st_q <= FEPC_H_IDLE;
					end
				end
				default:
				begin
					st_q  <= FEPC_H_IDLE;
					stb_q <= 1'b0;
				end
			endcase
		end
	end

	assign BUS.sfr_wr    = stb_q & (kind_q[idx_q] == FEPC_K_SFRW);
	assign BUS.sfr_rd    = stb_q & (kind_q[idx_q] == FEPC_K_SFRR);
	assign BUS.xmov_wr   = stb_q & (kind_q[idx_q] == FEPC_K_XMOV);
	assign BUS.sfr_addr  = addr_q[idx_q][7:0];
	assign BUS.sfr_wdata = data_q[idx_q];
	assign BUS.xmov_addr = addr_q[idx_q];
	assign BUS.xmov_data = data_q[idx_q];
	assign BUS.int_en    = inten_q;
endmodule

// ---- rtl/fepc_flash_ctl.sv ----
// flash erase and program control: register decode, erase starts and byte program
`timescale 1ns/1ps
module fepc_flash_ctl
	import fepc_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              SYS_RST,
	fepc_if.dev                    BUS,
	input  wire logic              DEBUG_EN,
	output logic                   FL_PAGE_ERASE,
	output logic                   FL_MASS_ERASE,
	output logic                   FL_PROG,
	output logic [PAGE_W-1:0]      FL_PAGE,
	output logic [15:0]            FL_ADDR,
	output logic [7:0]             FL_DATA,
	input  wire logic              FL_DONE,
	output logic                   RAM_WE,
	output logic [15:0]            RAM_ADDR,
	output logic [7:0]             RAM_DATA,
	output logic                   LOW_CURRENT
);
	import fepc_pkg::*;

	typedef enum logic {
		FEPC_D_IDLE,
		FEPC_D_BUSY
	} fepc_dst_e;

	fepc_dst_e         st_q;
	logic              ready_q;
	logic              meen_q;
	logic              pwe_q;
	logic              pg_valid_q;
	logic [PAGE_W-1:0] pgadr_q;
	logic [7:0]        rdata_q;
	logic              rvalid_q;
	logic              sfr_wr_ok;
	logic              sfr_rd_ok;
	logic              xmov_ok;
	logic              wr_trig;
	logic              wr_ctl;
	logic              wr_page;
	logic              page_go;
	logic              mass_go;
	logic              prog_go;
	logic              erase_go;
	logic              to_cfg;

	// nothing is taken while an operation runs, so no access can disturb it
	assign sfr_wr_ok = BUS.sfr_wr & ready_q;
	assign sfr_rd_ok = BUS.sfr_rd & ready_q;
	assign xmov_ok   = BUS.xmov_wr & ready_q;
	assign wr_trig   = sfr_wr_ok & (BUS.sfr_addr == SFR_ERASE_TRIG);
	assign wr_ctl    = sfr_wr_ok & (BUS.sfr_addr == SFR_FLASH_CTL);
	assign wr_page   = sfr_wr_ok & (BUS.sfr_addr == SFR_PAGE_ADDR);
	// the trigger holds no state: a pattern acts in the cycle it is written, any other
	// value falls through both compares and the trigger reads back as zero
	assign page_go   = wr_trig & (BUS.sfr_wdata == PAT_PAGE_ERASE) & pg_valid_q;
	assign mass_go   = wr_trig & (BUS.sfr_wdata == PAT_MASS_ERASE)
		& meen_q & DEBUG_EN;
	assign erase_go  = page_go | mass_go;
	assign to_cfg    = (BUS.xmov_addr == CFG_XADDR);
	assign prog_go   = xmov_ok & pwe_q;

	// operation sequencer
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			st_q    <= FEPC_D_IDLE;
			ready_q <= 1'b0;
		end
		else
		begin
			case (st_q)
				FEPC_D_IDLE:
				begin
					if (erase_go | prog_go)
					begin
						st_q    <= FEPC_D_BUSY;
						ready_q <= 1'b0;
					end
					else
					begin
						ready_q <= 1'b1;
					end
				end
				FEPC_D_BUSY:
				begin
					if (FL_DONE)
					begin
						st_q    <= FEPC_D_IDLE;
						ready_q <= 1'b1;
					end
				end
				default:
				begin
					st_q    <= FEPC_D_IDLE;
					ready_q <= 1'b0;
				end
			endcase
		end
	end

	// mass erase enable, write only
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			meen_q <= 1'b0;
		end
		else if (erase_go)
		begin
			meen_q <= 1'b0;
		end
		else if (wr_ctl)
		begin
			meen_q <= BUS.sfr_wdata[MEEN_BIT];
		end
	end

	// program write enable; cleared by hardware once the byte is handed to the array
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			pwe_q <= 1'b0;
		end
		else if (prog_go)
		begin
			pwe_q <= 1'b0;
		end
		else if (wr_ctl && !BUS.int_en)
		begin
			pwe_q <= BUS.sfr_wdata[PWE_BIT];
		end
	end

	// page erase address, consumed by any erase start so a stale page cannot be hit
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			pgadr_q    <= '0;
			pg_valid_q <= 1'b0;
		end
		else if (erase_go)
		begin
			pg_valid_q <= 1'b0;
		end
		else if (wr_page)
		begin
			pgadr_q    <= BUS.sfr_wdata[PAGE_MSB:PAGE_LSB];
			pg_valid_q <= 1'b1;
		end
	end

	// commands to the flash array
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			FL_PAGE_ERASE <= 1'b0;
			FL_MASS_ERASE <= 1'b0;
			FL_PROG       <= 1'b0;
			FL_PAGE       <= '0;
			FL_ADDR       <= '0;
			FL_DATA       <= BYTE_ZERO;
		end
		else
		begin
			FL_PAGE_ERASE <= page_go;
			FL_MASS_ERASE <= mass_go;
			FL_PROG       <= prog_go;
			if (page_go)
			begin
				FL_PAGE <= pgadr_q;
			end
			if (prog_go)
			begin
				FL_ADDR <= BUS.xmov_addr;
				FL_DATA <= BUS.xmov_data;
			end
		end
	end

	// ordinary external data writes; the configuration byte is kept here, not in RAM
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			RAM_WE   <= 1'b0;
			RAM_ADDR <= '0;
			RAM_DATA <= BYTE_ZERO;
		end
		else
		begin
			RAM_WE <= xmov_ok & ~pwe_q & ~to_cfg;
			if (xmov_ok && !pwe_q)
			begin
				RAM_ADDR <= BUS.xmov_addr;
				RAM_DATA <= BUS.xmov_data;
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			LOW_CURRENT <= LOWCUR_RST;
		end
		else if (xmov_ok && !pwe_q && to_cfg)
		begin
			LOW_CURRENT <= BUS.xmov_data[LOWCUR_BIT];
		end
	end

	// register read-back: only the write enable reads, write-only fields read zero
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			rdata_q  <= BYTE_ZERO;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= sfr_rd_ok;
			if (sfr_rd_ok)
			begin
				rdata_q <= BYTE_ZERO;
				if (BUS.sfr_addr == SFR_FLASH_CTL)
				begin
					rdata_q[PWE_BIT] <= pwe_q;
				end
			end
		end
	end

	assign BUS.ready      = ready_q;
	assign BUS.sfr_rdata  = rdata_q;
	assign BUS.sfr_rvalid = rvalid_q;
endmodule

// ---- rtl/fepc_if.sv ----
// core-side bus between the microcontroller core and the flash control block
`timescale 1ns/1ps
interface fepc_if;
	logic        sfr_wr;
	logic        sfr_rd;
	logic [7:0]  sfr_addr;
	logic [7:0]  sfr_wdata;
	logic [7:0]  sfr_rdata;
	logic        sfr_rvalid;
	logic        xmov_wr;
	logic [15:0] xmov_addr;
	logic [7:0]  xmov_data;
	logic        int_en;
	logic        ready;
	modport core (
		output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xmov_wr, xmov_addr, xmov_data, int_en,
		input  sfr_rdata, sfr_rvalid, ready
	);
	modport dev (
		input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, xmov_wr, xmov_addr, xmov_data, int_en,
		output sfr_rdata, sfr_rvalid, ready
	);
endinterface

// ---- rtl/fepc_pkg.sv ----
// shared constants for the flash erase/program control block and its controller
package fepc_pkg;
	// special function register addresses
	localparam logic [7:0]  SFR_ERASE_TRIG = 8'h94;
	localparam logic [7:0]  SFR_FLASH_CTL  = 8'hB2;
	localparam logic [7:0]  SFR_PAGE_ADDR  = 8'hB7;
	// erase trigger patterns
	localparam logic [7:0]  PAT_PAGE_ERASE = 8'h55;
	localparam logic [7:0]  PAT_MASS_ERASE = 8'hAA;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	// field positions
	localparam int          PWE_BIT        = 0;
	localparam int          MEEN_BIT       = 1;
	localparam int          PAGE_LSB       = 1;
	localparam int          PAGE_MSB       = 7;
	localparam int          PAGE_W         = 7;
	// external data address of the configuration byte holding the low-current select
	localparam logic [15:0] CFG_XADDR      = 16'h2005;
	localparam int          LOWCUR_BIT     = 1;
	localparam logic        LOWCUR_RST     = 1'b0;
	// controller APB register offsets
	localparam logic [7:0]  APB_CMD        = 8'h00;
	localparam logic [7:0]  APB_ARG        = 8'h04;
	localparam logic [7:0]  APB_CFG        = 8'h08;
	localparam logic [7:0]  APB_STATUS     = 8'h0C;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
	// argument, configuration and status register fields
	localparam int          ARG_ADDR_LSB   = 0;
	localparam int          ARG_ADDR_MSB   = 15;
	localparam int          ARG_DATA_LSB   = 16;
	localparam int          ARG_DATA_MSB   = 23;
	localparam int          CFG_INTEN_BIT  = 0;
	localparam int          ST_BUSY_BIT    = 0;
	localparam int          ST_READY_BIT   = 1;
	localparam int          ST_RD_LSB      = 8;
	localparam int          ST_RD_MSB      = 15;
	// controller commands
	typedef enum logic [2:0] {
		FEPC_OP_NONE  = 3'h0,
		FEPC_OP_PAGE  = 3'h1,
		FEPC_OP_MASS  = 3'h2,
		FEPC_OP_PROG  = 3'h3,
		FEPC_OP_SFRW  = 3'h4,
		FEPC_OP_XWR   = 3'h5,
		FEPC_OP_SFRR  = 3'h6
	} fepc_op_e;
	// kinds of a single core access
	typedef enum logic [1:0] {
		FEPC_K_NONE,
		FEPC_K_SFRW,
		FEPC_K_XMOV,
		FEPC_K_SFRR
	} fepc_kind_e;
endpackage

// ---- testbench/fepc_chk.sv ----
// assertions on the core bus between controller and flash control block
`timescale 1ns/1ps
module fepc_chk
	import fepc_pkg::*;
(
	input wire logic       CLK,
	input wire logic       SYS_RST,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_rvalid,
	input wire logic       ready,
	input wire logic       DEBUG_EN,
	input wire logic       FL_PAGE_ERASE,
	input wire logic       FL_MASS_ERASE,
	input wire logic       FL_PROG,
	input wire logic       FL_DONE
);
	logic pg_q;
	logic me_q;
	logic op_q;
	logic trig;
	logic start;
	assign trig = sfr_wr && ready && sfr_addr == SFR_ERASE_TRIG;
	assign start = FL_PAGE_ERASE || FL_MASS_ERASE;
	// shadow of the arming writes, dropped by any erase start
	always_ff @(posedge CLK)
		if (SYS_RST || start) pg_q <= 1'b0;
		else if (sfr_wr && ready && sfr_addr == SFR_PAGE_ADDR) pg_q <= 1'b1;
	always_ff @(posedge CLK)
		if (SYS_RST || start) me_q <= 1'b0;
		else if (sfr_wr && ready && sfr_addr == SFR_FLASH_CTL) me_q <= sfr_wdata[MEEN_BIT];
	always_ff @(posedge CLK)
		if (SYS_RST) op_q <= 1'b0;
		else if (start || FL_PROG) op_q <= 1'b1;
		else if (FL_DONE) op_q <= 1'b0;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_page_go;
		trig && sfr_wdata == PAT_PAGE_ERASE && pg_q;
	endsequence
	sequence s_mass_go;
		trig && sfr_wdata == PAT_MASS_ERASE && me_q && DEBUG_EN;
	endsequence
	a_page_start: assert property (s_page_go |=> FL_PAGE_ERASE && !ready)
		else $error("page erase not started");
	a_page_stale: assert property (trig && sfr_wdata == PAT_PAGE_ERASE && !pg_q |=> !FL_PAGE_ERASE)
		else $error("stale page erase started");
	a_mass_start: assert property (s_mass_go |=> FL_MASS_ERASE && !ready)
		else $error("mass erase not started");
	a_mass_block: assert property (trig && sfr_wdata == PAT_MASS_ERASE && !(me_q && DEBUG_EN) |=> !FL_MASS_ERASE)
		else $error("blocked mass erase started");
	a_other_none: assert property (trig && sfr_wdata != PAT_PAGE_ERASE && sfr_wdata != PAT_MASS_ERASE |=> !start)
		else $error("other pattern acted");
	a_op_busy: assert property (start || FL_PROG |-> !ready)
		else $error("ready during start");
	a_busy_hold: assert property (op_q && !FL_DONE |=> !ready)
		else $error("ready before done");
	a_done_ready: assert property (op_q && FL_DONE |=> ready)
		else $error("ready late after done");
	a_read_answer: assert property (sfr_rd && ready |=> sfr_rvalid ##1 !sfr_rvalid)
		else $error("read answer wrong");
	a_req_hold: assert property (sfr_wr && !ready |=> sfr_wr && $stable(sfr_addr) && $stable(sfr_wdata))
		else $error("request dropped");
endmodule

// ---- testbench/test_flash_erase_program_control.sv ----
// self-checking bench: controller and flash control block joined by their core bus
`timescale 1ns/1ps
module test_flash_erase_program_control;
	import fepc_pkg::*;
	logic        clk, rst, psel, penable, pwrite, debug_en, fl_done;
	logic        pready, pslverr, rerr, fl_pe, fl_me, fl_pr, ram_we, low_cur;
	logic [7:0]  paddr, fl_data, ram_data;
	logic [6:0]  fl_page;
	logic [15:0] fl_addr, ram_addr;
	logic [31:0] pwdata, prdata, rdat, last_pg, last_fl, last_x;
	int          n_fail, n_compared, n_pe, n_me, n_pr, n_xw, b_pe, b_me, b_pr, b_xw, dcnt;
	fepc_if bus ();
	fepc_core_ctl fepc_core_ctl_i (.CLK(clk), .SYS_RST(rst), .BUS(bus.core), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	fepc_flash_ctl fepc_flash_ctl_i (.CLK(clk), .SYS_RST(rst), .BUS(bus.dev), .DEBUG_EN(debug_en),
		.FL_PAGE_ERASE(fl_pe), .FL_MASS_ERASE(fl_me), .FL_PROG(fl_pr), .FL_PAGE(fl_page), .FL_ADDR(fl_addr),
		.FL_DATA(fl_data), .FL_DONE(fl_done), .RAM_WE(ram_we), .RAM_ADDR(ram_addr),
		.RAM_DATA(ram_data), .LOW_CURRENT(low_cur));
	fepc_chk fepc_chk_i (.CLK(clk), .SYS_RST(rst), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd),
		.sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .sfr_rvalid(bus.sfr_rvalid), .ready(bus.ready),
		.DEBUG_EN(debug_en), .FL_PAGE_ERASE(fl_pe), .FL_MASS_ERASE(fl_me), .FL_PROG(fl_pr), .FL_DONE(fl_done));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// flash array stand-in: finishes every operation four cycles after its start pulse
	always @(posedge clk)
	begin
		fl_done <= 1'b0;
		if (fl_pe || fl_me || fl_pr) dcnt <= 3;
		else if (dcnt != 0) dcnt <= dcnt - 1;
		if (dcnt == 1) fl_done <= 1'b1;
		n_pe <= n_pe + fl_pe;
		n_me <= n_me + fl_me;
		n_pr <= n_pr + fl_pr;
		n_xw <= n_xw + ram_we;
		if (fl_pe) last_pg <= {25'h0, fl_page};
		if (fl_pr) last_fl <= {8'h00, fl_addr, fl_data};
		if (ram_we) last_x <= {8'h00, ram_addr, ram_data};
	end
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
		begin
			n_fail++;
			$display("BAD %0t apb timeout", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task cmd(input fepc_op_e op, input logic [31:0] arg);
		int k;
		apb(1'b1, APB_ARG, arg);
		apb(1'b1, APB_CMD, {29'h0, op});
		k = 0;
		do
		begin
			apb(1'b0, APB_STATUS, WORD_ZERO);
			k++;
		end
		while (rdat[1:0] !== 2'b10 && k < 40);
		chk(rdat[1:0], 2'b10, "idle");
	endtask
	function automatic logic [31:0] sw(input logic [15:0] a, input logic [7:0] d);
		return {8'h00, d, a};
	endfunction
	task ops(input int pe, input int me, input int pr, input int xw);
		chk(n_pe - b_pe, pe, "page erases");
		chk(n_me - b_me, me, "mass erases");
		chk(n_pr - b_pr, pr, "programs");
		chk(n_xw - b_xw, xw, "ram writes");
		b_pe = n_pe;
		b_me = n_me;
		b_pr = n_pr;
		b_xw = n_xw;
	endtask
	task t_reset;
		chk(low_cur, 1'b0, "low current");
		cmd(FEPC_OP_SFRR, sw(SFR_FLASH_CTL, 8'h00));
		chk(rdat[ST_RD_MSB:ST_RD_LSB], 8'h00, "ctl reset");
		apb(1'b0, 8'h10, WORD_ZERO);
		chk(rerr, 1'b1, "unmapped");
		$display("done t_reset");
	endtask
	task t_page;
		cmd(FEPC_OP_PAGE, 32'h7F);
		ops(1, 0, 0, 0);
		chk(last_pg, 32'h7F, "page");
		cmd(FEPC_OP_PAGE, 32'h0);
		ops(1, 0, 0, 0);
		chk(last_pg, 32'h0, "page");
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_PAGE_ERASE));
		ops(0, 0, 0, 0);
		apb(1'b1, APB_ARG, 32'h05);
		apb(1'b1, APB_CMD, {29'h0, FEPC_OP_PAGE});
		cmd(FEPC_OP_SFRW, sw(SFR_PAGE_ADDR, 8'h22));
		ops(1, 0, 0, 0);
		chk(last_pg, 32'h05, "page while busy");
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_PAGE_ERASE));
		ops(1, 0, 0, 0);
		chk(last_pg, 32'h11, "held page write");
		$display("done t_page");
	endtask
	task t_other;
		logic [7:0] v[6];
		v = '{8'h00, 8'h54, 8'h56, 8'hA9, 8'hAB, 8'hFF};
		cmd(FEPC_OP_SFRW, sw(SFR_PAGE_ADDR, 8'h1A));
		foreach (v[i])
			cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, v[i]));
		ops(0, 0, 0, 0);
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_PAGE_ERASE));
		ops(1, 0, 0, 0);
		chk(last_pg, 32'h0D, "page field");
		$display("done t_other");
	endtask
	task t_mass;
		debug_en <= 1'b0;
		cmd(FEPC_OP_MASS, WORD_ZERO);
		ops(0, 0, 0, 0);
		debug_en <= 1'b1;
		cmd(FEPC_OP_MASS, WORD_ZERO);
		ops(0, 1, 0, 0);
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_MASS_ERASE));
		ops(0, 0, 0, 0);
		cmd(FEPC_OP_SFRW, sw(SFR_FLASH_CTL, 8'h00));
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_MASS_ERASE));
		ops(0, 0, 0, 0);
		$display("done t_mass");
	endtask
	task t_prog;
		cmd(FEPC_OP_PROG, sw(16'h1234, 8'h5A));
		ops(0, 0, 1, 0);
		chk(last_fl, 32'h12345A, "program");
		cmd(FEPC_OP_XWR, sw(16'h0100, 8'h3C));
		ops(0, 0, 0, 1);
		chk(last_x, 32'h01003C, "ram write");
		cmd(FEPC_OP_SFRR, sw(SFR_FLASH_CTL, 8'h00));
		chk(rdat[ST_RD_LSB], 1'b0, "enable cleared");
		$display("done t_prog");
	endtask
	task t_inten;
		apb(1'b1, APB_CFG, 32'h1);
		cmd(FEPC_OP_SFRW, sw(SFR_FLASH_CTL, 8'h01));
		cmd(FEPC_OP_SFRR, sw(SFR_FLASH_CTL, 8'h00));
		chk(rdat[ST_RD_LSB], 1'b0, "enable ignored");
		cmd(FEPC_OP_XWR, sw(16'h0200, 8'hC3));
		ops(0, 0, 0, 1);
		apb(1'b1, APB_CFG, WORD_ZERO);
		cmd(FEPC_OP_SFRW, sw(SFR_FLASH_CTL, 8'h01));
		cmd(FEPC_OP_SFRR, sw(SFR_FLASH_CTL, 8'h00));
		chk(rdat[ST_RD_LSB], 1'b1, "enable set");
		cmd(FEPC_OP_XWR, sw(16'h0300, 8'h99));
		ops(0, 0, 1, 0);
		chk(last_fl, 32'h030099, "program");
		cmd(FEPC_OP_XWR, sw(CFG_XADDR, 8'h02));
		chk(low_cur, 1'b1, "low current");
		$display("done t_inten");
	endtask
	task t_rerst;
		cmd(FEPC_OP_SFRW, sw(SFR_FLASH_CTL, 8'h02));
		cmd(FEPC_OP_SFRW, sw(SFR_PAGE_ADDR, 8'h04));
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		chk(low_cur, 1'b0, "low current reset");
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_MASS_ERASE));
		cmd(FEPC_OP_SFRW, sw(SFR_ERASE_TRIG, PAT_PAGE_ERASE));
		ops(0, 0, 0, 0);
		$display("done t_rerst");
	endtask
	task test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		$display("BAD %0t watchdog", $time);
		test_done;
	end
	initial
	begin
		{rst, psel, penable, pwrite, debug_en} = 5'h11;
		paddr = 8'h00;
		pwdata = WORD_ZERO;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_page;
		t_other;
		t_mass;
		t_prog;
		t_inten;
		t_rerst;
		test_done;
	end
endmodule
